// file: fdrx_params.svh
// register offsets, reset values and sizes of the receive sorter
`ifndef FDRX_PARAMS_SVH
`define FDRX_PARAMS_SVH
`define FDRX_OFF_CTRL    8'h00
`define FDRX_OFF_TYPEA   8'h04
`define FDRX_OFF_TYPEB   8'h08
`define FDRX_OFF_WMARK   8'h0C
`define FDRX_OFF_BLEN0   8'h10
`define FDRX_OFF_BLEN1   8'h14
`define FDRX_OFF_BLEN4   8'h18
`define FDRX_OFF_RMODE   8'h1C
`define FDRX_OFF_STAT    8'h20
`define FDRX_CTRL_MODE_LSB 0
`define FDRX_CTRL_F0EN     2
`define FDRX_CTRL_F1EN     3
`define FDRX_CTRL_SENTEN   4
`define FDRX_CTRL_TCEEN    5
`define FDRX_TYPEA_TE      16
`define FDRX_RST_CTRL    6'h00
`define FDRX_RST_TYPE    17'h00000
`define FDRX_RST_WMARK   16'h0008
`define FDRX_RST_BLEN    16'h0010
`define FDRX_RST_RMODE   10'h000
`define FDRX_DEPTH       16
`define FDRX_PW          5
`endif

// file: fdrx_pkg.sv
// types shared by the receive sorter
package fdrx_pkg;
	typedef enum logic [1:0] {FDRX_NORMAL, FDRX_ALL, FDRX_ONEBUF, FDRX_SPLIT} fdrx_mode_t;
	typedef enum logic [1:0] {FDRX_K_DATA, FDRX_K_FRAME, FDRX_K_SENT, FDRX_K_TCE} fdrx_kind_t;
	typedef struct packed {
		logic       byte_tgl;  // toggles once per byte
		logic [7:0] data;
		logic       sof;
		logic       eof;       // end strobe, no data stored with it
		logic       bad;
		logic       crc_ok;
		logic [2:0] eac;
		logic       own;
		logic       refuse;
		logic       token_tgl; // toggles on token, claim or beacon
	} fdrx_mac_t;
	typedef struct packed {
		fdrx_kind_t  kind;
		logic [2:0]  ring;     // 0, 1 or 4
		logic        desc_end; // descriptor filled by this byte
		logic        last;
		logic        bad;
		logic        crc_ok;
		logic        keep_ptr; // buffer pointer left unchanged
		logic [2:0]  eac;
		logic [15:0] len;
		logic [7:0]  data;
	} fdrx_entry_t;
	typedef struct packed {
		logic       written;  // indication written back
		logic       net_done; // sent to network or aborted
		logic       lm_done;  // fully in local memory
		logic [1:0] ring;
	} fdrx_tx_t;
endpackage : fdrx_pkg

// file: fdrx_top.sv
// receive sorting, abort, receive modes and event indications
//
// Notes on behaviour
// - small staging FIFO holds incoming frame bytes
// - frame control picks FIFO via type registers
// - type clear in both registers aborts
// - selected FIFO disabled aborts frame
// - full FIFO aborts and flags overrun
// - refuse input during frame aborts it
// - normal mode: bad frame kept past watermark
// - early abort rewinds, buffer reused
// - receive-all passes every byte, errors too
// - one-buffer keeps only first buffer length
// - one-buffer still gives full status
// - split header goes ring four
// - own sent frames give E/A/C indication
// - token cycle end indication after transmission
// - event indications keep buffer pointer
// - four transmit, two receive ring modes
// - transmit done only after indication written
// - local mode indication at net or local
// - frame done after data and indications written
// - drain starts at watermark, at fifo one short of full, or at frame end
// - indication per descriptor, last holds status
//
// Design decisions made here: the register addresses and the APB register port.
`include "fdrx_params.svh"
`timescale 1ns/1ps
module fdrx_top (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// mac pins
	input  wire fdrx_pkg::fdrx_mac_t mac_in,
	output logic                     rx_abort,
	// transmit side events, same clock
	input  wire logic                tx_frame_sent,
	input  wire fdrx_pkg::fdrx_tx_t  tx_evt,
	output logic                     tx_ind_req,
	output logic [1:0]               tx_ind_ring,
	output logic                     tx_cmd_done,
	output logic [9:0]               ring_mode,
	// entries towards host memory
	output logic                     out_valid,
	output fdrx_pkg::fdrx_entry_t    out_entry,
	input  wire logic                out_ready,
	output logic                     rx_frame_done
);
	import fdrx_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [5:0]              ctrl_reg;
	logic [16:0]             typea_reg;
	logic [16:0]             typeb_reg;
	logic [15:0]             wmark_reg;
	logic [15:0]             blen0_reg;
	logic [15:0]             blen1_reg;
	logic [15:0]             blen4_reg;
	logic [9:0]              rmode_reg;
	logic                    ovr_reg;
	logic                    tce_arm_reg;
	logic [15:0]             done_cnt_reg;
	logic                    ovr_set;
	logic                    wr_en;
	logic                    rd_ok;
	logic [31:0]             rd_val;
	fdrx_mode_t              mode;

	assign mode  = fdrx_mode_t'(ctrl_reg[`FDRX_CTRL_MODE_LSB +: 2]);
	assign wr_en = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			// one wait state keeps read data straight from a flop
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !rd_ok;
			prdata  <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`FDRX_OFF_CTRL:  rd_val = {26'h0, ctrl_reg};
			`FDRX_OFF_TYPEA: rd_val = {15'h0, typea_reg};
			`FDRX_OFF_TYPEB: rd_val = {15'h0, typeb_reg};
			`FDRX_OFF_WMARK: rd_val = {16'h0, wmark_reg};
			`FDRX_OFF_BLEN0: rd_val = {16'h0, blen0_reg};
			`FDRX_OFF_BLEN1: rd_val = {16'h0, blen1_reg};
			`FDRX_OFF_BLEN4: rd_val = {16'h0, blen4_reg};
			`FDRX_OFF_RMODE: rd_val = {22'h0, rmode_reg};
			`FDRX_OFF_STAT:  rd_val = {done_cnt_reg, 14'h0, tce_arm_reg, ovr_reg};
			default:         rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= `FDRX_RST_CTRL;
			typea_reg <= `FDRX_RST_TYPE;
			typeb_reg <= `FDRX_RST_TYPE;
			wmark_reg <= `FDRX_RST_WMARK;
			blen0_reg <= `FDRX_RST_BLEN;
			blen1_reg <= `FDRX_RST_BLEN;
			blen4_reg <= `FDRX_RST_BLEN;
			rmode_reg <= `FDRX_RST_RMODE;
		end else if (wr_en) begin
			case (paddr)
				`FDRX_OFF_CTRL:  ctrl_reg  <= pwdata[5:0];
				`FDRX_OFF_TYPEA: typea_reg <= pwdata[16:0];
				`FDRX_OFF_TYPEB: typeb_reg <= pwdata[16:0];
				`FDRX_OFF_WMARK: wmark_reg <= pwdata[15:0];
				`FDRX_OFF_BLEN0: blen0_reg <= pwdata[15:0];
				`FDRX_OFF_BLEN1: blen1_reg <= pwdata[15:0];
				`FDRX_OFF_BLEN4: blen4_reg <= pwdata[15:0];
				`FDRX_OFF_RMODE: rmode_reg <= pwdata[9:0];
				default: ;
			endcase
		end
	end

	// overrun is write-one-to-clear; a new overrun wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovr_reg <= 1'b0;
		else if (ovr_set)
			ovr_reg <= 1'b1;
		else if (wr_en && paddr == `FDRX_OFF_STAT && pwdata[0])
			ovr_reg <= 1'b0;
	end

	// ----------------------------------------
	// mac pin synchroniser
	// ----------------------------------------
	fdrx_mac_t mac_s1;
	fdrx_mac_t mac_s2;
	logic      byte_d;
	logic      tok_d;
	logic      byte_ev;
	logic      tok_ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_s1 <= '0;
			mac_s2 <= '0;
			byte_d <= 1'b0;
			tok_d  <= 1'b0;
		end else begin
			mac_s1 <= mac_in;
			mac_s2 <= mac_s1;
			byte_d <= mac_s2.byte_tgl;
			tok_d  <= mac_s2.token_tgl;
		end
	end
	assign byte_ev = mac_s2.byte_tgl ^ byte_d;
	assign tok_ev  = mac_s2.token_tgl ^ tok_d;

	// ----------------------------------------
	// staging fifo and frame sorter
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_RECV, ST_SENT, ST_CLOSE} fdrx_st_t;

	fdrx_entry_t             mem_q [`FDRX_DEPTH];
	fdrx_st_t                st_reg;
	logic [`FDRX_PW-1:0]     wr_ptr_reg;
	logic [`FDRX_PW-1:0]     rd_ptr_reg;
	logic [`FDRX_PW-1:0]     frm_ptr_reg;
	logic [`FDRX_PW-1:0]     level;
	logic                    full;
	logic [15:0]             tot_len_reg;
	logic [15:0]             buf_cnt_reg;
	logic [15:0]             hdr_cnt_reg;
	logic [2:0]              ring_reg;
	logic                    bad_reg;
	logic                    commit_reg;
	logic [2:0]              dst;
	logic [15:0]             dst_len;
	logic                    store;
	logic                    tce_pend_reg;
	logic                    first_reg;

	assign level = wr_ptr_reg - rd_ptr_reg;
	assign full  = level == 5'(`FDRX_DEPTH);

	function automatic logic [15:0] blen_of(input logic [2:0] r);
		case (r)
			3'h0:    blen_of = blen0_reg;
			3'h1:    blen_of = blen1_reg;
			default: blen_of = blen4_reg;
		endcase
	endfunction : blen_of

	function automatic fdrx_entry_t ind_of(input fdrx_kind_t k, input logic [2:0] r,
			input logic b, input logic [15:0] l);
		ind_of          = '0;
		ind_of.kind     = k;
		ind_of.ring     = r;
		ind_of.last     = 1'b1;
		ind_of.bad      = b;
		ind_of.crc_ok   = mac_s2.crc_ok;
		ind_of.eac      = mac_s2.eac;
		ind_of.keep_ptr = k != FDRX_K_FRAME;
		ind_of.len      = l;
	endfunction : ind_of

	// header bytes go to ring four, the rest follow the frame's ring
	always_comb begin
		dst = ring_reg;
		if (mode == FDRX_SPLIT && hdr_cnt_reg < blen4_reg)
			dst = 3'h4;
		dst_len = blen_of(dst);
		store   = !(mode == FDRX_ONEBUF && tot_len_reg >= blen_of(ring_reg));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= ST_IDLE;
			wr_ptr_reg   <= '0;
			frm_ptr_reg  <= '0;
			tot_len_reg  <= 16'h0000;
			buf_cnt_reg  <= 16'h0000;
			hdr_cnt_reg  <= 16'h0000;
			ring_reg     <= 3'h0;
			bad_reg      <= 1'b0;
			commit_reg   <= 1'b0;
			rx_abort     <= 1'b0;
			ovr_set      <= 1'b0;
			tce_pend_reg <= 1'b0;
			first_reg    <= 1'b0;
		end else begin
			ovr_set   <= 1'b0;
			rx_abort  <= 1'b0;
			first_reg <= 1'b0;
			case (st_reg)
				ST_IDLE: begin
					if (tce_pend_reg && !full) begin
						mem_q[wr_ptr_reg[3:0]] <= ind_of(FDRX_K_TCE,
							{2'b00, typea_reg[`FDRX_TYPEA_TE]}, 1'b0, 16'h0000);
						wr_ptr_reg   <= wr_ptr_reg + 5'h01;
						frm_ptr_reg  <= wr_ptr_reg + 5'h01;
						tce_pend_reg <= 1'b0;
					end else if (byte_ev && mac_s2.sof) begin
						tot_len_reg <= 16'h0000;
						buf_cnt_reg <= 16'h0000;
						hdr_cnt_reg <= 16'h0000;
						bad_reg     <= 1'b0;
						commit_reg  <= 1'b0;
						// frame control byte is stored one cycle later
						first_reg   <= 1'b1;
						ring_reg    <= typea_reg[mac_s2.data[7:4]] ? 3'h0 : 3'h1;
						if (mac_s2.own && ctrl_reg[`FDRX_CTRL_SENTEN])
							st_reg <= ST_SENT;
						else if (!typea_reg[mac_s2.data[7:4]] && !typeb_reg[mac_s2.data[7:4]])
							rx_abort <= 1'b1;
						else if (!ctrl_reg[typea_reg[mac_s2.data[7:4]] ?
								`FDRX_CTRL_F0EN : `FDRX_CTRL_F1EN])
							rx_abort <= 1'b1;
						else if (mac_s2.refuse)
							rx_abort <= 1'b1;
						else
							st_reg <= ST_RECV;
					end
				end
				ST_SENT: begin
					// own frame: only its length and the flags seen at its end are reported
					if (byte_ev && mac_s2.eof && !full) begin
						mem_q[wr_ptr_reg[3:0]] <= ind_of(FDRX_K_SENT, ring_reg, 1'b0,
							tot_len_reg);
						wr_ptr_reg  <= wr_ptr_reg + 5'h01;
						frm_ptr_reg <= wr_ptr_reg + 5'h01;
						st_reg      <= ST_IDLE;
					end else if (byte_ev)
						tot_len_reg <= tot_len_reg + 16'h0001;
				end
				ST_RECV: begin
					if (byte_ev && (mac_s2.refuse || mac_s2.eof && mac_s2.bad)) begin
						rx_abort <= mac_s2.refuse;
						if (mode == FDRX_ALL || commit_reg && tot_len_reg > wmark_reg) begin
							bad_reg <= 1'b1;
							st_reg  <= ST_CLOSE;
						end else begin
							wr_ptr_reg <= frm_ptr_reg;
							st_reg     <= ST_IDLE;
						end
					end else if (byte_ev && mac_s2.eof) begin
						commit_reg <= 1'b1;
						st_reg     <= ST_CLOSE;
					end else if ((byte_ev || first_reg) && store && full) begin
						rx_abort <= 1'b1;
						ovr_set  <= 1'b1;
						if (mode == FDRX_ALL || commit_reg) begin
							bad_reg <= 1'b1;
							st_reg  <= ST_CLOSE;
						end else begin
							wr_ptr_reg <= frm_ptr_reg;
							st_reg     <= ST_IDLE;
						end
					end else if (byte_ev || first_reg) begin
						tot_len_reg <= tot_len_reg + 16'h0001;
						if (store) begin
							mem_q[wr_ptr_reg[3:0]]          <= '0;
							mem_q[wr_ptr_reg[3:0]].kind     <= FDRX_K_DATA;
							mem_q[wr_ptr_reg[3:0]].ring     <= dst;
							mem_q[wr_ptr_reg[3:0]].data     <= mac_s2.data;
							mem_q[wr_ptr_reg[3:0]].desc_end <= buf_cnt_reg + 16'h0001 >= dst_len;
							wr_ptr_reg <= wr_ptr_reg + 5'h01;
							buf_cnt_reg <= (buf_cnt_reg + 16'h0001 >= dst_len ||
								dst != ring_reg && hdr_cnt_reg + 16'h0001 >= blen4_reg) ?
								16'h0000 : buf_cnt_reg + 16'h0001;
							if (dst == 3'h4)
								hdr_cnt_reg <= hdr_cnt_reg + 16'h0001;
							// the fifo must drain before it can fill
							if (tot_len_reg + 16'h0001 >= wmark_reg || level == 5'(`FDRX_DEPTH - 1))
								commit_reg <= 1'b1;
						end
					end
				end
				ST_CLOSE: begin
					if (!full) begin
						mem_q[wr_ptr_reg[3:0]] <= ind_of(FDRX_K_FRAME, ring_reg,
							bad_reg || mac_s2.bad, tot_len_reg);
						wr_ptr_reg  <= wr_ptr_reg + 5'h01;
						frm_ptr_reg <= wr_ptr_reg + 5'h01;
						st_reg      <= ST_IDLE;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
			// set after the case so a new token beats the clear
			if (tok_ev && ctrl_reg[`FDRX_CTRL_TCEEN] && tce_arm_reg)
				tce_pend_reg <= 1'b1;
		end
	end

	// transmissions this token cycle; a send in the token cycle end wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tce_arm_reg <= 1'b0;
		else if (tx_frame_sent)
			tce_arm_reg <= 1'b1;
		else if (tok_ev)
			tce_arm_reg <= 1'b0;
	end

	// ----------------------------------------
	// drain towards host memory
	// ----------------------------------------
	logic [`FDRX_PW-1:0] lim;
	logic                load;

	assign lim  = commit_reg ? wr_ptr_reg : frm_ptr_reg;
	assign load = (!out_valid || out_ready) && rd_ptr_reg != lim;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_reg    <= '0;
			out_valid     <= 1'b0;
			out_entry     <= '0;
			rx_frame_done <= 1'b0;
			done_cnt_reg  <= 16'h0000;
		end else begin
			rx_frame_done <= 1'b0;
			if (out_valid && out_ready && out_entry.kind == FDRX_K_FRAME) begin
				rx_frame_done <= 1'b1;
				done_cnt_reg  <= done_cnt_reg + 16'h0001;
			end
			if (load) begin
				out_entry  <= mem_q[rd_ptr_reg[3:0]];
				out_valid  <= 1'b1;
				rd_ptr_reg <= rd_ptr_reg + 5'h01;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// transmit indication timing per ring mode
	// ----------------------------------------
	logic lm_mode;
	logic at_lm;

	assign lm_mode = rmode_reg[tx_evt.ring];
	assign at_lm   = rmode_reg[6 + tx_evt.ring];
	assign ring_mode = rmode_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ind_req  <= 1'b0;
			tx_ind_ring <= 2'b00;
			tx_cmd_done <= 1'b0;
		end else begin
			// local ring with early indication stays silent on net outcome
			tx_ind_req  <= lm_mode && at_lm ? tx_evt.lm_done : tx_evt.net_done;
			tx_ind_ring <= tx_evt.ring;
			tx_cmd_done <= tx_evt.written;
		end
	end

endmodule : fdrx_top

// file: fdrx_top_properties.sv
// concurrent checks on the receive sorter ports
`timescale 1ns/1ps
module fdrx_top_properties (
	// clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// apb
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	// receive and transmit events
	input wire logic                  rx_abort,
	input wire fdrx_pkg::fdrx_tx_t    tx_evt,
	input wire logic                  tx_ind_req,
	input wire logic [1:0]            tx_ind_ring,
	input wire logic                  tx_cmd_done,
	input wire logic [9:0]            ring_mode,
	// host side entries
	input wire logic                  out_valid,
	input wire fdrx_pkg::fdrx_entry_t out_entry,
	input wire logic                  out_ready,
	input wire logic                  rx_frame_done
);
	import fdrx_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// helper: frame status accepted last cycle
	// ----
	logic frame_acc_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) frame_acc_reg <= 1'b0;
		else frame_acc_reg <= out_valid && out_ready && out_entry.kind == FDRX_K_FRAME;
	end
	// ----
	// properties
	// ----
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("apb answer late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_abort_pulse; rx_abort |=> !rx_abort; endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort held");
	property p_cmd_done; tx_evt.written |=> tx_cmd_done; endproperty
	a_cmd_done: assert property (p_cmd_done) else $error("command done missing");
	property p_cmd_cause; tx_cmd_done |-> $past(tx_evt.written); endproperty
	a_cmd_cause: assert property (p_cmd_cause) else $error("command done early");
	property p_ind_net;
		tx_evt.net_done && !tx_evt.lm_done
			&& !(ring_mode[tx_evt.ring] && ring_mode[4'd6 + tx_evt.ring])
			|=> tx_ind_req && tx_ind_ring == $past(tx_evt.ring);
	endproperty
	a_ind_net: assert property (p_ind_net) else $error("network indication missing");
	property p_ind_lm;
		tx_evt.lm_done && !tx_evt.net_done
			&& ring_mode[tx_evt.ring] && ring_mode[4'd6 + tx_evt.ring]
			|=> tx_ind_req && tx_ind_ring == $past(tx_evt.ring);
	endproperty
	a_ind_lm: assert property (p_ind_lm) else $error("local indication missing");
	property p_no_net;
		tx_evt.net_done && !tx_evt.lm_done
			&& ring_mode[tx_evt.ring] && ring_mode[4'd6 + tx_evt.ring] |=> !tx_ind_req;
	endproperty
	a_no_net: assert property (p_no_net) else $error("extra network indication");
	property p_done; rx_frame_done == frame_acc_reg; endproperty
	a_done: assert property (p_done) else $error("frame done mistimed");
	property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_entry); endproperty
	a_hold: assert property (p_hold) else $error("entry dropped while stalled");
	property p_keep;
		out_valid && out_entry.kind inside {FDRX_K_SENT, FDRX_K_TCE} |-> out_entry.keep_ptr;
	endproperty
	a_keep: assert property (p_keep) else $error("event moved pointer");
	property p_last; out_valid && out_entry.kind == FDRX_K_FRAME |-> out_entry.last; endproperty
	a_last: assert property (p_last) else $error("status not last");
	property p_ring; out_valid |-> out_entry.ring inside {3'd0, 3'd1, 3'd4}; endproperty
	a_ring: assert property (p_ring) else $error("bad ring");
endmodule : fdrx_top_properties
bind fdrx_top fdrx_top_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .rx_abort(rx_abort), .tx_evt(tx_evt),
	.tx_ind_req(tx_ind_req), .tx_ind_ring(tx_ind_ring), .tx_cmd_done(tx_cmd_done),
	.ring_mode(ring_mode), .out_valid(out_valid), .out_entry(out_entry),
	.out_ready(out_ready), .rx_frame_done(rx_frame_done));

// file: fdrx_mac_model.sv
// behavioural ring controller driving the receive pins
`timescale 1ns/1ps
module fdrx_mac_model (
	// clock
	input wire logic            pclk,
	// pins toward the sorter
	output fdrx_pkg::fdrx_mac_t mac
);
	import fdrx_pkg::*;
	initial mac = '0;
	// ----
	// events, held past the sync delay
	// ----
	task automatic ev(input logic [7:0] d, input logic s, e, b, rf, ow);
		mac.data <= d;
		mac.sof <= s;
		mac.eof <= e;
		mac.bad <= b;
		mac.crc_ok <= !b;
		mac.refuse <= rf;
		mac.own <= ow;
		mac.eac <= 3'h5;
		mac.byte_tgl <= !mac.byte_tgl;
		repeat (4) @(posedge pclk);
		// stale byte would hide a late sample
		mac.data <= ~d;
		@(posedge pclk);
	endtask : ev
	task automatic frame(input logic [7:0] b[$], input logic bd, ow, input int rf);
		foreach (b[i]) begin
			ev(b[i], i == 0, 1'b0, 1'b0, i == rf, ow);
			if (i == rf) return;
		end
		ev(~b[0], 1'b0, 1'b1, bd, 1'b0, ow);
	endtask : frame
	task automatic token();
		mac.token_tgl <= !mac.token_tgl;
		repeat (5) @(posedge pclk);
	endtask : token
endmodule : fdrx_mac_model

// file: tb_fdrx_top.sv
// self-checking bench of the receive sorter
`include "fdrx_params.svh"
`timescale 1ns/1ps
module tb_fdrx_top;
	import fdrx_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, pslverr, rx_abort, tx_ind_req, tx_cmd_done, out_valid, rx_frame_done;
	logic [1:0]  tx_ind_ring;
	logic [9:0]  ring_mode;
	fdrx_mac_t   mac_in;
	logic        tx_frame_sent = 0, out_ready = 0, stall = 0, ign = 0;
	fdrx_tx_t    tx_evt = '0;
	fdrx_entry_t out_entry, q[$];
	logic [7:0]  bq[$];
	integer      seed = 32'h4729f3d9;
	int          fails = 0, tests_run = 0, seen_ab = 0, exp_ab = 0;
	logic [7:0]  ro[7] = '{`FDRX_OFF_CTRL, `FDRX_OFF_TYPEA, `FDRX_OFF_TYPEB, `FDRX_OFF_WMARK,
		`FDRX_OFF_BLEN4, `FDRX_OFF_RMODE, 8'h40};
	logic [31:0] rv[7] = '{32'(`FDRX_RST_CTRL), 32'(`FDRX_RST_TYPE), 32'(`FDRX_RST_TYPE),
		32'(`FDRX_RST_WMARK), 32'(`FDRX_RST_BLEN), 32'(`FDRX_RST_RMODE), 32'h0};
	always #20 pclk = ~pclk;
	fdrx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mac_in(mac_in), .rx_abort(rx_abort), .tx_frame_sent(tx_frame_sent),
		.tx_evt(tx_evt), .tx_ind_req(tx_ind_req), .tx_ind_ring(tx_ind_ring),
		.tx_cmd_done(tx_cmd_done), .ring_mode(ring_mode), .out_valid(out_valid),
		.out_entry(out_entry), .out_ready(out_ready), .rx_frame_done(rx_frame_done));
	fdrx_mac_model u_mac (.pclk(pclk), .mac(mac_in));
	// ----
	// compare and closing
	// ----
	task automatic cmp(input logic [31:0] g, e, input string m);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmp
	task automatic cmp_e(input fdrx_entry_t g, e);
		logic ok;
		ok = g.kind === e.kind && g.ring === e.ring;
		if (e.kind == FDRX_K_DATA) ok = ok && g.data === e.data && g.desc_end === e.desc_end;
		else if (e.kind == FDRX_K_FRAME)
			ok = ok && g.last === 1'b1 && {g.len, g.bad, g.crc_ok} === {e.len, e.bad, e.crc_ok};
		else ok = ok && g.keep_ptr === 1'b1 && (e.kind == FDRX_K_TCE || g.eac === e.eac);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t entry got %h exp %h", $time, g, e);
		end
	endtask : cmp_e
	task automatic stop_test();
		if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	function automatic fdrx_entry_t mk(fdrx_kind_t k, logic [2:0] rg, logic [7:0] d, int l, logic b);
		mk = '0;
		mk.kind = k;
		mk.ring = rg;
		mk.data = d;
		mk.len = 16'(l);
		mk.bad = b;
		mk.crc_ok = !b;
		mk.eac = 3'h5;
	endfunction : mk
	// ----
	// output monitor, randomly stalling
	// ----
	always @(posedge pclk) begin
		if (rx_abort === 1'b1) seen_ab++;
		if (out_valid === 1'b1 && out_ready === 1'b1 && !ign) begin
			if (q.size() == 0) begin
				fails++;
				$display("MISMATCH %0t unexpected entry", $time);
			end else cmp_e(out_entry, q.pop_front());
		end
		out_ready <= !stall && ($random(seed) % 2 != 0);
	end
	// ----
	// drivers
	// ----
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, input logic er);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		cmp({31'h0, pready}, 32'h1, "ready");
		if (!w) cmp(prdata & m, d & m, "read");
		cmp({31'h0, pslverr}, {31'h0, er}, "slverr");
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic settle();
		int n;
		n = 0;
		while (q.size() != 0 && n < 800) begin
			@(posedge pclk);
			n++;
		end
		cmp(q.size(), 0, "entries missing");
		q.delete();
		repeat (10) @(posedge pclk);
		cmp(seen_ab, exp_ab, "aborts");
	endtask : settle
	task automatic go(input logic [3:0] t, input int n, k, h, input logic bd, input int rf,
			input logic [2:0] rg, input int ab, input logic ow);
		fdrx_entry_t e;
		bq.delete();
		for (int i = 0; i < n; i++) bq.push_back(i == 0 ? {t, 4'($random(seed))} : 8'($random(seed)));
		for (int i = 0; i < k; i++) begin
			e = mk(FDRX_K_DATA, i < h ? 3'd4 : rg, bq[i], 0, 0);
			// a descriptor closes each time its ring's buffer length fills
			e.desc_end = ((i < h ? i : i - h) + 1) %
				(i < h ? 3 : rg == 0 ? 4 : `FDRX_RST_BLEN) == 0;
			q.push_back(e);
		end
		if (k >= 0) q.push_back(mk(FDRX_K_FRAME, rg, 0, n, bd));
		if (ow) q.push_back(mk(FDRX_K_SENT, rg, 0, 0, 0));
		exp_ab += ab;
		u_mac.frame(bq, bd, ow, rf);
		settle();
	endtask : go
	// ----
	// main sequence
	// ----
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		foreach (ro[i]) apb(0, ro[i], rv[i], '1, i == 6);
		apb(1, `FDRX_OFF_TYPEA, 32'h0001_0020, 0, 0);
		apb(1, `FDRX_OFF_TYPEB, 32'h40, 0, 0);
		apb(1, `FDRX_OFF_BLEN0, 32'h4, 0, 0);
		apb(1, `FDRX_OFF_BLEN4, 32'h3, 0, 0);
		apb(1, `FDRX_OFF_RMODE, 32'h30F, 0, 0);
		apb(0, `FDRX_OFF_RMODE, 32'h30F, '1, 0);
		cmp({22'h0, ring_mode}, 32'h30F, "ring mode");
		apb(1, `FDRX_OFF_CTRL, 32'h3C, 0, 0);
		go(5, 6, 6, 0, 0, -1, 0, 0, 0);
		go(6, 5, 5, 0, 0, -1, 1, 0, 0);
		go(2, 4, -1, 0, 0, -1, 0, 1, 0);
		apb(1, `FDRX_OFF_CTRL, 32'h34, 0, 0);
		go(6, 4, -1, 0, 0, -1, 1, 1, 0);
		apb(1, `FDRX_OFF_CTRL, 32'h3C, 0, 0);
		go(5, 6, -1, 0, 0, 3, 0, 1, 0);
		go(5, 4, -1, 0, 1, -1, 0, 0, 0);
		go(5, 12, 12, 0, 1, -1, 0, 0, 0);
		go(5, 4, -1, 0, 0, -1, 0, 0, 1);
		apb(1, `FDRX_OFF_CTRL, 32'h3D, 0, 0);
		go(5, 3, 3, 0, 1, -1, 0, 0, 0);
		apb(1, `FDRX_OFF_CTRL, 32'h3E, 0, 0);
		go(5, 10, 4, 0, 0, -1, 0, 0, 0);
		apb(1, `FDRX_OFF_CTRL, 32'h3F, 0, 0);
		go(5, 7, 7, 3, 0, -1, 0, 0, 0);
		apb(1, `FDRX_OFF_CTRL, 32'h3C, 0, 0);
		tx_frame_sent <= 1;
		@(posedge pclk);
		tx_frame_sent <= 0;
		q.push_back(mk(FDRX_K_TCE, 3'd1, 0, 0, 0));
		u_mac.token();
		settle();
		u_mac.token();
		settle();
		stall <= 1;
		go(5, 30, -1, 0, 0, -1, 0, 1, 0);
		apb(0, `FDRX_OFF_STAT, 32'h0006_0001, 32'hFFFF_0001, 0);
		apb(1, `FDRX_OFF_STAT, 32'h1, 0, 0);
		apb(0, `FDRX_OFF_STAT, 32'h0, 32'h1, 0);
		ign = 1;
		stall <= 0;
		repeat (200) @(posedge pclk);
		ign = 0;
		repeat (80) begin
			r = $random(seed);
			tx_evt <= {r[0], r[1], !r[1] & r[2], r[4:3]};
			@(posedge pclk);
		end
		tx_evt <= '0;
		repeat (4) @(posedge pclk);
		stop_test();
	end
	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		stop_test();
	end
endmodule : tb_fdrx_top
